// file: rtl/bru_pkg.sv
// Purpose: Shared constants and types for the byte rotate unit
// Assumes: 8-bit data, one carry flag, operation codes set by the core decoder
// Notes:   Operation codes are chosen locally; the decoder maps onto them
//
// How it works
// - Left rotate to accumulator, memory and flags kept
// - Left rotate through carry, in place
// - Left rotate through carry into accumulator
// - Right rotate in place, flags kept
// - Right rotate to accumulator, memory and flags kept
// - Right rotate through carry, in place
package bru_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and bit positions
  localparam int unsigned DATA_W  = 8;        // Operand width
  localparam int unsigned MSB_POS = 7;        // Top bit of the byte
  localparam int unsigned LSB_POS = 0;        // Bottom bit of the byte
  localparam logic        CARRY_RESET = 1'h0; // Carry after reset
  localparam logic [7:0]  BYTE_RESET  = 8'h00; // Result registers after reset

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes
  typedef enum logic [2:0] {
    BRU_OP_ROTATE_LEFT_COPY_OUT          = 3'b000,
    BRU_OP_ROTATE_LEFT_VIA_FLAG          = 3'b001,
    BRU_OP_ROTATE_LEFT_VIA_FLAG_COPY_OUT = 3'b010,
    BRU_OP_ROTATE_RIGHT_IN_PLACE         = 3'b011,
    BRU_OP_ROTATE_RIGHT_COPY_OUT         = 3'b100,
    BRU_OP_ROTATE_RIGHT_VIA_FLAG         = 3'b101
  } bru_op_t;

  // Request carried from the core
  typedef struct packed {
    bru_op_t    op;      // Which rotate
    logic [7:0] operand; // Memory byte read by the core
  } bru_req_t;

  // Result carried back to the core
  typedef struct packed {
    logic [7:0] data;     // Rotated byte
    logic       to_acc;   // High: write accumulator, low: write memory
    logic       carry_wr; // Carry flag updated by this operation
  } bru_res_t;

endpackage : bru_pkg

// file: rtl/bru_rotator.sv
// Purpose: Combinational rotate of one byte with optional carry path
// Assumes: Inputs are the original operand and carry (no feedback)
// Notes:   Pure logic; registering is done by the top
`timescale 1ns/1ps
`default_nettype none
module bru_rotator (
  // Operand
  input  wire logic [7:0]      data_in,
  input  wire logic            carry_in,
  input  wire bru_pkg::bru_op_t op_in,
  // Result
  output logic [7:0]           data_out,
  output logic                 carry_out,
  output logic                 to_acc_out,
  output logic                 carry_wr_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Shift left by one; fill enters the bottom bit
  function automatic logic [7:0] shift_left_fill(input logic [7:0] value, input logic fill);
    return {value[bru_pkg::MSB_POS-1:bru_pkg::LSB_POS], fill};
  endfunction : shift_left_fill

  // Shift right by one; fill enters the top bit
  function automatic logic [7:0] shift_right_fill(input logic [7:0] value, input logic fill);
    return {fill, value[bru_pkg::MSB_POS:bru_pkg::LSB_POS+1]};
  endfunction : shift_right_fill

  ////////////////////////////////////////////////////////////////////////////
  // Shifts read only the inputs, so no partial update can leak in
  always_comb begin
    data_out     = data_in;
    carry_out    = carry_in;
    to_acc_out   = 1'b0;
    carry_wr_out = 1'b0;
    unique case (op_in)
      bru_pkg::BRU_OP_ROTATE_LEFT_COPY_OUT: begin
        data_out   = shift_left_fill(data_in, data_in[bru_pkg::MSB_POS]);
        to_acc_out = 1'b1;
      end
      bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG: begin
        data_out     = shift_left_fill(data_in, carry_in);
        carry_out    = data_in[bru_pkg::MSB_POS];
        carry_wr_out = 1'b1;
      end
      bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG_COPY_OUT: begin
        data_out     = shift_left_fill(data_in, carry_in);
        carry_out    = data_in[bru_pkg::MSB_POS];
        to_acc_out   = 1'b1;
        carry_wr_out = 1'b1;
      end
      bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE: begin
        data_out = shift_right_fill(data_in, data_in[bru_pkg::LSB_POS]);
      end
      bru_pkg::BRU_OP_ROTATE_RIGHT_COPY_OUT: begin
        data_out   = shift_right_fill(data_in, data_in[bru_pkg::LSB_POS]);
        to_acc_out = 1'b1;
      end
      bru_pkg::BRU_OP_ROTATE_RIGHT_VIA_FLAG: begin
        data_out     = shift_right_fill(data_in, carry_in);
        carry_out    = data_in[bru_pkg::LSB_POS];
        carry_wr_out = 1'b1;
      end
      // Unused codes: byte goes back to memory unchanged, no accumulator or carry write
      default: begin
        data_out = data_in;
      end
    endcase
  end

endmodule : bru_rotator
`default_nettype wire

// file: rtl/bru_top.sv
// Purpose: Byte rotate unit of the core datapath, registered results
// Assumes: Core presents operand, carry and operation with a start strobe
// Notes:   One cycle latency; result and carry held until the next start, done and strobes pulse once
`timescale 1ns/1ps
`default_nettype none
module bru_top (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              clk_en_in,
  // Request
  input  wire logic              start_in,
  input  wire bru_pkg::bru_req_t req_in,
  input  wire logic              carry_in,
  // Result
  output logic                   done_out,
  output bru_pkg::bru_res_t      res_out,
  output logic                   carry_out,
  output logic                   acc_we_out,
  output logic                   mem_we_out,
  output logic                   carry_we_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Combinational rotate
  logic [7:0] rot_data;   // Rotated byte
  logic       rot_carry;  // New carry
  logic       rot_acc;    // Destination accumulator
  logic       rot_cwr;    // Carry written

  bru_rotator u_rot (
    .data_in      (req_in.operand),
    .carry_in     (carry_in),
    .op_in        (req_in.op),
    .data_out     (rot_data),
    .carry_out    (rot_carry),
    .to_acc_out   (rot_acc),
    .carry_wr_out (rot_cwr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result registers
  bru_pkg::bru_res_t res_q, res_d;     // Held result
  logic              carry_q, carry_d; // Held carry
  logic              done_q, done_d;   // Completion pulse

  // Next values; on start carry loads carry_in unless the operation writes it, else it is kept
  always_comb begin
    res_d   = res_q;
    carry_d = carry_q;
    done_d  = 1'b0;
    if (start_in) begin
      res_d.data     = rot_data;
      res_d.to_acc   = rot_acc;
      res_d.carry_wr = rot_cwr;
      carry_d        = rot_cwr ? rot_carry : carry_in;
      done_d         = 1'b1;
    end
  end

  // Register only; clock enable freezes everything
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      res_q   <= '{data: bru_pkg::BYTE_RESET, to_acc: 1'b0, carry_wr: 1'b0};
      carry_q <= bru_pkg::CARRY_RESET;
      done_q  <= 1'b0;
    end else if (clk_en_in) begin
      res_q   <= res_d;
      carry_q <= carry_d;
      done_q  <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: strobes gate writes so the memory byte is kept on copy-out ops
  assign res_out      = res_q;
  assign carry_out    = carry_q;
  assign done_out     = done_q;
  assign acc_we_out   = done_q & res_q.to_acc;
  assign mem_we_out   = done_q & ~res_q.to_acc;
  assign carry_we_out = done_q & res_q.carry_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_left_copy;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_LEFT_COPY_OUT)
    |=> (res_out.data == {$past(req_in.operand[6:0]), $past(req_in.operand[7])})
        && acc_we_out && !carry_we_out && !mem_we_out;
  endproperty
  a_left_copy: assert property (p_left_copy) else $error("left copy-out wrong");

  property p_left_flag;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG)
    |=> res_out.data == {$past(req_in.operand[6:0]), $past(carry_in)}
        && carry_out == $past(req_in.operand[7]) && mem_we_out && carry_we_out;
  endproperty
  a_left_flag: assert property (p_left_flag) else $error("left via carry wrong");

  property p_left_flag_copy;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG_COPY_OUT)
    |=> res_out.data == {$past(req_in.operand[6:0]), $past(carry_in)}
        && carry_out == $past(req_in.operand[7]) && acc_we_out && !mem_we_out;
  endproperty
  a_left_flag_copy: assert property (p_left_flag_copy) else $error("left carry copy wrong");

  property p_right_place;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE)
    |=> res_out.data == {$past(req_in.operand[0]), $past(req_in.operand[7:1])}
        && mem_we_out && !carry_we_out;
  endproperty
  a_right_place: assert property (p_right_place) else $error("right in place wrong");

  property p_right_copy;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_RIGHT_COPY_OUT)
    |=> res_out.data == {$past(req_in.operand[0]), $past(req_in.operand[7:1])}
        && acc_we_out && !carry_we_out && carry_out == $past(carry_in);
  endproperty
  a_right_copy: assert property (p_right_copy) else $error("right copy-out wrong");

  property p_right_flag;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_RIGHT_VIA_FLAG)
    |=> res_out.data == {$past(carry_in), $past(req_in.operand[7:1])}
        && carry_out == $past(req_in.operand[0]) && mem_we_out && carry_we_out;
  endproperty
  a_right_flag: assert property (p_right_flag) else $error("right via carry wrong");

  property p_one_dest;
    @(posedge clk_in) disable iff (reset_in)
    done_out |-> (acc_we_out != mem_we_out)
                 ##1 (!done_out || $past(start_in) || !$past(clk_en_in));
  endproperty
  a_one_dest: assert property (p_one_dest) else $error("destination strobes wrong");

  property p_hold;
    @(posedge clk_in) disable iff (reset_in)
    !clk_en_in |=> $stable(res_out) && $stable(carry_out) && $stable(done_out);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while disabled");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the quiet paths: carry pass-through, idle cycles, unused codes
  // and reset. These catch a stuck strobe or a stale result that the per-op
  // checks above would never see.

  // Unused codes must not touch accumulator or carry, only rewrite the byte
  property p_unused_op;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op > bru_pkg::BRU_OP_ROTATE_RIGHT_VIA_FLAG)
    |=> res_out.data == $past(req_in.operand) && carry_out == $past(carry_in)
        && mem_we_out && !acc_we_out && !carry_we_out;
  endproperty
  a_unused_op: assert property (p_unused_op) else $error("unused code wrote state");

  // Left copy-out leaves the carry flag alone
  property p_left_copy_carry;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_LEFT_COPY_OUT)
    |=> carry_out == $past(carry_in) && !carry_we_out;
  endproperty
  a_left_copy_carry: assert property (p_left_copy_carry) else $error("left copy moved carry");

  // Right in place leaves the carry flag and accumulator alone
  property p_right_place_carry;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in && req_in.op == bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE)
    |=> carry_out == $past(carry_in) && !acc_we_out;
  endproperty
  a_right_place_carry: assert property (p_right_place_carry) else $error("right place moved carry");

  // Every taken request answers exactly one edge later
  property p_done_taken;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && start_in) |=> done_out;
  endproperty
  a_done_taken: assert property (p_done_taken) else $error("request not answered");

  // No request, no strobes
  property p_done_idle;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && !start_in) |=> !done_out && !acc_we_out && !mem_we_out && !carry_we_out;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("strobe without request");

  // Result and carry stand until the next taken request
  property p_idle_hold;
    @(posedge clk_in) disable iff (reset_in)
    (clk_en_in && !start_in) |=> $stable(res_out) && $stable(carry_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("result moved while idle");

  // Reset clears the result, the carry and the strobes
  property p_reset_clear;
    @(posedge clk_in)
    reset_in |=> !done_out && res_out.data == bru_pkg::BYTE_RESET
                 && carry_out == bru_pkg::CARRY_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear state");

endmodule : bru_top
`default_nettype wire

// file: dv/byte_rotate_unit_tb_top.sv
// Purpose: Self-checking bench for the byte rotate unit
// Assumes: One request per enabled edge, result one edge later
// Notes:   Inputs move on the falling edge so the rising edge sees them settled
`timescale 1ns/1ps
`default_nettype none
module byte_rotate_unit_tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus, observation and bookkeeping
  logic              clk_in          = 1'h0;   // 40 MHz core clock
  logic              reset_in        = 1'h1;   // Async reset, held at start
  logic              clk_en_in       = 1'h1;   // Clock enable
  logic              start_in        = 1'h0;   // Request strobe
  bru_pkg::bru_req_t req_in          = 11'h000; // Operation and operand
  logic              carry_in        = 1'h0;   // Carry before the op
  logic              done_out;                 // Result valid pulse
  bru_pkg::bru_res_t res_out;                  // Rotated byte and target
  logic              carry_out;                // New carry
  logic              acc_we_out;               // Accumulator write
  logic              mem_we_out;               // Memory write
  logic              carry_we_out;             // Carry write
  logic [14:0]       obs;                      // All outputs in one vector
  logic [10:0]       held_q          = 11'h000; // Result that must stay put
  int                fail_count      = 0;      // Mismatches
  int                samples_checked = 0;      // Comparisons made
  int                cycles          = 0;      // Hang guard
  assign obs = {res_out, carry_out, done_out, acc_we_out, mem_we_out, carry_we_out};
  // Clock generator
  always #12.5 clk_in = ~clk_in;
  bru_top DUT (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .start_in(start_in), .req_in(req_in), .carry_in(carry_in), .done_out(done_out),
    .res_out(res_out), .carry_out(carry_out), .acc_we_out(acc_we_out),
    .mem_we_out(mem_we_out), .carry_we_out(carry_we_out));
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Expected {data, to_acc, carry_wr, carry}; old carry passes when not written
  function automatic logic [10:0] expect_res(bru_pkg::bru_op_t op, logic [7:0] x, logic c);
    case (op)
      bru_pkg::BRU_OP_ROTATE_LEFT_COPY_OUT:          return {x[6:0], x[7], 2'h2, c};
      bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG:          return {x[6:0], c, 2'h1, x[7]};
      bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG_COPY_OUT: return {x[6:0], c, 2'h3, x[7]};
      bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE:         return {x[0], x[7:1], 2'h0, c};
      bru_pkg::BRU_OP_ROTATE_RIGHT_COPY_OUT:         return {x[0], x[7:1], 2'h2, c};
      bru_pkg::BRU_OP_ROTATE_RIGHT_VIA_FLAG:         return {c, x[7:1], 2'h1, x[0]};
      default:                                       return {x, 2'h0, c};
    endcase
  endfunction : expect_res
  task automatic cmp(input logic [14:0] exp, input string what);
    samples_checked++;
    if (obs !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, obs, exp);
    end
  endtask : cmp
  // Request taken at the next rising edge, judged one falling edge later
  task automatic send(input bru_pkg::bru_op_t op, input logic [7:0] x, input logic c);
    logic [10:0] e;
    e = expect_res(op, x, c);
    req_in = {op, x};
    carry_in = c;
    start_in = 1'h1;
    @(negedge clk_in);
    held_q = e;
    cmp({e[10:1], e[0], 1'h1, e[2], ~e[2], e[1]}, "result");
  endtask : send
  // Strobes must drop while the result holds
  task automatic idle(input string name);
    start_in = 1'h0;
    @(negedge clk_in);
    cmp({held_q, 4'h0}, "idle");
    $display("test %s finished", name);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios; two sends back to back exercise consecutive requests
  task automatic test_left_copy();
    send(bru_pkg::BRU_OP_ROTATE_LEFT_COPY_OUT, 8'h81, 1'h0);
    send(bru_pkg::BRU_OP_ROTATE_LEFT_COPY_OUT, 8'h40, 1'h1);
    idle("left copy");
  endtask : test_left_copy
  task automatic test_left_flag();
    send(bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG, 8'h80, 1'h0);
    send(bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG, 8'h01, 1'h1);
    idle("left flag");
  endtask : test_left_flag
  task automatic test_left_flag_copy();
    send(bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG_COPY_OUT, 8'h7F, 1'h1);
    send(bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG_COPY_OUT, 8'h80, 1'h0);
    idle("left flag copy");
  endtask : test_left_flag_copy
  task automatic test_right_place();
    send(bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE, 8'h01, 1'h0);
    send(bru_pkg::BRU_OP_ROTATE_RIGHT_IN_PLACE, 8'h80, 1'h1);
    idle("right in place");
  endtask : test_right_place
  task automatic test_right_copy();
    send(bru_pkg::BRU_OP_ROTATE_RIGHT_COPY_OUT, 8'h01, 1'h0);
    send(bru_pkg::BRU_OP_ROTATE_RIGHT_COPY_OUT, 8'hFE, 1'h1);
    idle("right copy");
  endtask : test_right_copy
  task automatic test_right_flag();
    send(bru_pkg::BRU_OP_ROTATE_RIGHT_VIA_FLAG, 8'h01, 1'h0);
    send(bru_pkg::BRU_OP_ROTATE_RIGHT_VIA_FLAG, 8'h80, 1'h1);
    idle("right flag");
  endtask : test_right_flag
  // Unused codes rewrite the byte unchanged, carry passes through
  task automatic test_unused_code();
    send(bru_pkg::bru_op_t'(3'h6), 8'hA5, 1'h1);
    send(bru_pkg::bru_op_t'(3'h7), 8'h3C, 1'h0);
    idle("unused code");
  endtask : test_unused_code
  // Disabled clock must freeze everything; a reset in mid-run clears it
  task automatic test_enable_reset();
    clk_en_in = 1'h0;
    req_in = {bru_pkg::BRU_OP_ROTATE_LEFT_VIA_FLAG, 8'hFF};
    start_in = 1'h1;
    repeat (2) @(negedge clk_in);
    cmp({held_q, 4'h0}, "frozen");
    clk_en_in = 1'h1;
    idle("enable");
    reset_in = 1'h1;
    @(negedge clk_in);
    cmp(15'h0000, "mid reset");
    reset_in = 1'h0;
    held_q = 11'h000;
    idle("reset");
  endtask : test_enable_reset
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard; about 30 cycles are expected
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(negedge clk_in);
    cmp(15'h0000, "reset");
    reset_in = 1'h0;
    test_left_copy();
    test_left_flag();
    test_left_flag_copy();
    test_right_place();
    test_right_copy();
    test_right_flag();
    test_unused_code();
    test_enable_reset();
    wrap_up();
  end
endmodule : byte_rotate_unit_tb_top
`default_nettype wire
